// ===== hw/uart_status_flags.v
// Status flags, control bits and mode select of one asynchronous serial channel.
// Assumes the shifter, bit timing and DMA controller run on i_clk and give
// one-cycle event pulses; the register file is a classic Wishbone slave.
//
// Decided for this implementation: register access over Wishbone.

`timescale 1ns/1ns

`include "uart_status_flags_consts.vh"

module uart_status_flags #(
    parameter ADDR_W = 26,
    parameter DATA_W = 8
) (
    input wire i_clk,
    input wire i_arst_n,
    // Wishbone classic slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [ADDR_W-1:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output wire [31:0] o_wb_dat,
    output wire o_wb_ack,
    // Transmit machinery
    input wire i_tx_load,
    input wire i_tx_last_bit,
    // Receive machinery
    input wire i_rx_done,
    input wire [DATA_W-1:0] i_rx_data,
    input wire i_rx_framing_err,
    input wire i_rx_parity_err,
    // DMA controller write of new transmit data
    input wire i_dma_wr,
    input wire [DATA_W-1:0] i_dma_data,
    // Outputs toward the channel and system
    output wire [DATA_W-1:0] o_tx_holding,
    output wire o_tx_enable,
    output wire o_rx_enable,
    output wire o_smart_card_mode_sel,
    output wire o_tx_data_request,
    output wire o_rx_full_request,
    output wire o_rx_error_request,
    output wire o_irq
);

    // ****************************************************************
    // Reset release
    // ****************************************************************

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    // Async assert, two-flop release so no flop leaves reset on a ragged edge
    // Costs two cycles of start-up latency; the bus must wait for them
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Only the second flop feeds the design
    assign rst_n = rst_sync_reg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    reg ack_reg;
    reg [31:0] rdat_reg;
    reg [31:0] rdat_next;
    reg [7:0] status_reg;
    reg [7:0] status_next;
    reg [7:0] control_reg;
    reg [7:0] control_next;
    reg [7:0] mode_reg;
    reg [7:0] mode_next;
    reg [7:0] irq_stat_reg;
    reg [7:0] irq_stat_next;
    reg [7:0] irq_mask_reg;
    reg [7:0] irq_mask_next;
    reg [7:0] armed_reg;
    reg [7:0] armed_next;
    reg [DATA_W-1:0] tx_hold_reg;
    reg [DATA_W-1:0] tx_hold_next;
    reg [DATA_W-1:0] rx_hold_reg;
    reg [DATA_W-1:0] rx_hold_next;

    wire req;
    wire wr_take;
    wire rd_take;
    wire lane0;
    wire [ADDR_W-3:0] idx;
    wire hit_ctrl;
    wire hit_txh;
    wire hit_stat;
    wire hit_rxh;
    wire hit_mode;
    wire hit_istat;
    wire hit_imask;
    wire [7:0] wbyte;

    // Request is new while no ack stands; the effects land on the ack edge
    // One wait state: ack follows the request by one cycle, then drops
    assign req = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr_take = i_wb_cyc & i_wb_stb & ack_reg & i_wb_we;
    assign rd_take = i_wb_cyc & i_wb_stb & ack_reg & ~i_wb_we;
    assign lane0 = i_wb_sel[0];
    assign idx = i_wb_adr[ADDR_W-1:2];
    assign wbyte = i_wb_dat[7:0];

    // Word index compare; unmapped words read zero and ignore writes
    // Only indices are decoded; the two low address bits are ignored
    assign hit_ctrl = (idx == `IDX_SERIAL_CONTROL);
    assign hit_txh = (idx == `IDX_TX_HOLDING);
    assign hit_stat = (idx == `IDX_SERIAL_STATUS);
    assign hit_rxh = (idx == `IDX_RX_HOLDING);
    assign hit_mode = (idx == `IDX_SMART_CARD_MODE);
    assign hit_istat = (idx == `IDX_IRQ_STATUS);
    assign hit_imask = (idx == `IDX_IRQ_MASK);

    // Read data is captured one edge before the ack edge
    always @* begin
        rdat_next = 32'h00000000;
        if (req && !i_wb_we) begin
            if (hit_ctrl) begin
                rdat_next[7:0] = control_reg;
            end else if (hit_txh) begin
                rdat_next[DATA_W-1:0] = tx_hold_reg;
            end else if (hit_stat) begin
                rdat_next[7:0] = status_reg;
            end else if (hit_rxh) begin
                rdat_next[DATA_W-1:0] = rx_hold_reg;
            end else if (hit_mode) begin
                rdat_next[7:0] = mode_reg;
            end else if (hit_istat) begin
                rdat_next[7:0] = irq_stat_reg;
            end else if (hit_imask) begin
                rdat_next[7:0] = irq_mask_reg;
            end
        end else if (ack_reg) begin
            // Hold the word while ack stands so the master samples it steady
            rdat_next = rdat_reg;
        end
    end

    // ****************************************************************
    // Channel events
    // ****************************************************************

    wire tx_en;
    wire rx_en;
    wire rx_clean;
    wire rx_overrun;
    wire dma_refill;
    wire sw_clr_tx_buffer_empty;
    wire [7:0] sw_clear;
    wire [7:0] set_ev;

    // Enables come straight from the control register
    assign tx_en = control_reg[`BIT_TX_ENABLE];
    assign rx_en = control_reg[`BIT_RX_ENABLE];

    // Errored characters never reach the holding register
    // Clean end of reception while the holding register is free
    assign rx_clean = i_rx_done & ~i_rx_framing_err & ~i_rx_parity_err
        & ~status_reg[`BIT_RX_BUFFER_FULL];
    // Data still unread: new character is dropped
    assign rx_overrun = i_rx_done & status_reg[`BIT_RX_BUFFER_FULL];
    // Refill pulse comes straight from the DMA side on the same clock
    assign dma_refill = i_dma_wr;

    // Zero write clears only a bit that was seen as one before
    assign sw_clear = (wr_take && hit_stat && lane0)
        ? (~wbyte & armed_reg & `STATUS_W0C_MASK) : 8'h00;
    assign sw_clr_tx_buffer_empty = sw_clear[`BIT_TX_BUFFER_EMPTY];

    // Hardware set events, one bit per status flag
    assign set_ev[`BIT_TX_BUFFER_EMPTY] = ~tx_en | i_tx_load;
    assign set_ev[`BIT_RX_BUFFER_FULL] = rx_clean;
    assign set_ev[`BIT_OVERRUN] = rx_overrun;
    assign set_ev[`BIT_FRAMING_ERROR] = i_rx_done & i_rx_framing_err;
    assign set_ev[`BIT_PARITY_ERROR] = i_rx_done & i_rx_parity_err;
    assign set_ev[`BIT_TX_END] = ~tx_en
        | (i_tx_last_bit & status_reg[`BIT_TX_BUFFER_EMPTY]);
    assign set_ev[1:0] = 2'b00;

    // ****************************************************************
    // Status register
    // ****************************************************************

    // Set wins over any clear landing in the same cycle
    always @* begin
        status_next = status_reg & ~sw_clear;
        // DMA refill also empties the empty flag
        if (dma_refill) begin
            status_next[`BIT_TX_BUFFER_EMPTY] = 1'b0;
        end
        // Transmit end follows every clear of the empty flag
        if (dma_refill || sw_clr_tx_buffer_empty) begin
            status_next[`BIT_TX_END] = 1'b0;
        end
        // Receive enable is not looked at, so disabling keeps the flag
        status_next = status_next | set_ev;
        // Bits 1 and 0 are not implemented and read as zero
        status_next[1:0] = 2'b00;
    end

    // Track bits that a status read returned as one; a status write with byte lane 0 selected disarms
    // A flag that sets after the read stays unarmed, so a late zero write cannot lose it
    always @* begin
        armed_next = armed_reg;
        if (rd_take && hit_stat) begin
            armed_next = rdat_reg[7:0] & `STATUS_W0C_MASK;
        end else if (wr_take && hit_stat && lane0) begin
            armed_next = 8'h00;
        end
    end

    // ****************************************************************
    // Control, mode and data registers
    // ****************************************************************

    // Software writes land on the ack edge; only byte lane 0 carries data
    always @* begin
        control_next = control_reg;
        mode_next = mode_reg;
        irq_mask_next = irq_mask_reg;
        tx_hold_next = tx_hold_reg;
        if (wr_take && lane0) begin
            if (hit_ctrl) begin
                // Only the four enable bits exist; the others read back zero
                control_next = 8'h00;
                control_next[`BIT_TX_IRQ_ENABLE] = wbyte[`BIT_TX_IRQ_ENABLE];
                control_next[`BIT_RX_IRQ_ENABLE] = wbyte[`BIT_RX_IRQ_ENABLE];
                control_next[`BIT_TX_ENABLE] = wbyte[`BIT_TX_ENABLE];
                control_next[`BIT_RX_ENABLE] = wbyte[`BIT_RX_ENABLE];
            end
            if (hit_mode) begin
                mode_next = {7'h00, wbyte[`BIT_SMART_CARD_SEL]};
            end
            if (hit_imask) begin
                // Mask follows the status layout: the five flags and transmit end
                irq_mask_next = wbyte & `STATUS_W0C_MASK;
                irq_mask_next[`BIT_TX_END] = wbyte[`BIT_TX_END];
            end
            if (hit_txh) begin
                tx_hold_next = wbyte[DATA_W-1:0];
            end
        end
        // DMA data wins over a CPU write in the same cycle
        if (dma_refill) begin
            tx_hold_next = i_dma_data;
        end
    end

    // Only a clean character reaches the holding register
    always @* begin
        rx_hold_next = rx_hold_reg;
        if (rx_clean) begin
            rx_hold_next = i_rx_data;
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************

    wire [7:0] irq_rd_clear;
    wire [7:0] irq_rise;

    // Only bits that were returned by the read are cleared
    assign irq_rd_clear = (rd_take && hit_istat) ? rdat_reg[7:0] : 8'h00;
    // Sticky bits catch a flag rising, so a held flag does not refire
    assign irq_rise = status_next & ~status_reg;

    // Read clear and a new rise in one cycle: the rise wins
    always @* begin
        irq_stat_next = (irq_stat_reg & ~irq_rd_clear) | irq_rise;
        // Unused low bits can never raise the interrupt
        irq_stat_next[1:0] = 2'b00;
    end

    // ****************************************************************
    // State update
    // ****************************************************************

    // One register bank, updated on every edge; reset is the synchronised copy
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
            status_reg <= `RST_SERIAL_STATUS;
            armed_reg <= 8'h00;
            control_reg <= `RST_SERIAL_CONTROL;
            mode_reg <= `RST_SMART_CARD_MODE;
            irq_stat_reg <= 8'h00;
            irq_mask_reg <= `RST_IRQ_MASK;
            tx_hold_reg <= `RST_HOLDING;
            rx_hold_reg <= `RST_HOLDING;
        end else begin
            ack_reg <= req;
            rdat_reg <= rdat_next;
            status_reg <= status_next;
            armed_reg <= armed_next;
            control_reg <= control_next;
            mode_reg <= mode_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            tx_hold_reg <= tx_hold_next;
            rx_hold_reg <= rx_hold_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Bus and channel outputs all come from flops
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    assign o_tx_holding = tx_hold_reg;
    assign o_tx_enable = tx_en;
    assign o_rx_enable = rx_en;
    // Mode bit steers the rest of the channel
    assign o_smart_card_mode_sel = mode_reg[`BIT_SMART_CARD_SEL];

    // Requests gated by the tx and rx interrupt enable bits of control; the DMA controller refills on tx request
    // Built from flops only, so the DMA side never sees a decode glitch
    assign o_tx_data_request = status_reg[`BIT_TX_BUFFER_EMPTY]
        & control_reg[`BIT_TX_IRQ_ENABLE];
    assign o_rx_full_request = status_reg[`BIT_RX_BUFFER_FULL]
        & control_reg[`BIT_RX_IRQ_ENABLE];
    assign o_rx_error_request = (status_reg[`BIT_OVERRUN]
        | status_reg[`BIT_FRAMING_ERROR] | status_reg[`BIT_PARITY_ERROR])
        & control_reg[`BIT_RX_IRQ_ENABLE];

    // Level interrupt while any unmasked sticky bit stands
    // Limitation: a flag held high raises its sticky bit only once
    assign o_irq = |(irq_stat_reg & irq_mask_reg);

endmodule // uart_status_flags

// ===== hw/uart_status_flags_consts.vh
// Constants for the serial channel status-flag and mode-select block.
// Assumes a 32-bit classic Wishbone slave with byte addresses = 4 x register index.

`ifndef UART_STATUS_FLAGS_CONSTS_VH
`define UART_STATUS_FLAGS_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_SERIAL_CONTROL 24'hFFFF82
`define IDX_TX_HOLDING 24'hFFFF83
`define IDX_SERIAL_STATUS 24'hFFFF84
`define IDX_RX_HOLDING 24'hFFFF85
`define IDX_SMART_CARD_MODE 24'hFFFF86
`define IDX_IRQ_STATUS 24'hFFFF88
`define IDX_IRQ_MASK 24'hFFFF89

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_TX_BUFFER_EMPTY 7
`define BIT_RX_BUFFER_FULL 6
`define BIT_OVERRUN 5
`define BIT_FRAMING_ERROR 4
`define BIT_PARITY_ERROR 3
`define BIT_TX_END 2
`define BIT_SMART_CARD_SEL 0
`define BIT_TX_IRQ_ENABLE 7
`define BIT_RX_IRQ_ENABLE 6
`define BIT_TX_ENABLE 5
`define BIT_RX_ENABLE 4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SERIAL_STATUS 8'h84
`define RST_SERIAL_CONTROL 8'h00
`define RST_SMART_CARD_MODE 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_HOLDING 8'h00

// Status bits that software may clear by writing zero
`define STATUS_W0C_MASK 8'hF8

`endif

// ===== tb/uart_status_flags_assertions.sv
// Port-level checks for the serial status block, bound to its top module.
// Assumes one clock i_clk and the register header on the include path.
`timescale 1ns/1ns
`include "uart_status_flags_consts.vh"
module uart_status_flags_assertions #(
    parameter ADDR_W = 26,
    parameter DATA_W = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_wb_we,
    input wire logic o_wb_ack,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic i_tx_load,
    input wire logic i_rx_done,
    input wire logic i_rx_framing_err,
    input wire logic i_rx_parity_err,
    input wire logic i_dma_wr,
    input wire logic o_tx_enable,
    input wire logic o_smart_card_mode_sel,
    input wire logic o_tx_data_request,
    input wire logic o_rx_full_request,
    input wire logic o_rx_error_request
);
    // ********************
    // Helpers
    // ********************
    // A write lands at the edge where ack is seen
    wire wr_land = o_wb_ack && i_wb_we && i_wb_sel[0];
    wire ctl_wr = wr_land && (i_wb_adr[ADDR_W-1:2] == `IDX_SERIAL_CONTROL);
    wire sc_wr = wr_land && (i_wb_adr[ADDR_W-1:2] == `IDX_SMART_CARD_MODE);
    // Any receive request high proves receive requests are enabled
    wire rx_en_seen = o_rx_full_request || o_rx_error_request;
    wire rx_ok = i_rx_done && !i_rx_framing_err && !i_rx_parity_err;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_tx_req_holds: assert property (o_tx_data_request && !i_dma_wr && !o_wb_ack
        |=> o_tx_data_request) else $error("tx request dropped without cause");
    a_dma_clears_req: assert property (i_dma_wr && !i_tx_load && o_tx_enable && !o_wb_ack
        |=> !o_tx_data_request) else $error("dma write left tx request up");
    a_tx_off_sets: assert property (ctl_wr && i_wb_dat[7] && !i_wb_dat[5]
        |=> ##1 o_tx_data_request) else $error("tx disable did not set empty");
    a_req_gating: assert property (ctl_wr |=> ($past(i_wb_dat[7]) || !o_tx_data_request)
        && ($past(i_wb_dat[6]) || !rx_en_seen)) else $error("request not gated");
    a_rx_full_sets: assert property (rx_ok && rx_en_seen && !o_wb_ack
        |=> o_rx_full_request) else $error("clean reception did not set full");
    a_rx_full_holds: assert property (o_rx_full_request && !o_wb_ack
        |=> o_rx_full_request) else $error("full flag lost without write");
    a_overrun_sets: assert property (i_rx_done && o_rx_full_request && !o_wb_ack
        |=> o_rx_error_request) else $error("overrun not flagged");
    a_rx_err_sets: assert property (i_rx_done && (i_rx_framing_err || i_rx_parity_err)
        && rx_en_seen && !o_wb_ack |=> o_rx_error_request && $stable(o_rx_full_request))
        else $error("receive error not flagged");
    a_rx_err_holds: assert property (o_rx_error_request && !o_wb_ack
        |=> o_rx_error_request) else $error("error flag lost without write");
    a_mode_sel_write: assert property (sc_wr
        |=> o_smart_card_mode_sel == $past(i_wb_dat[0])) else $error("mode select write lost");
    a_mode_sel_stable: assert property (!o_wb_ack
        |=> $stable(o_smart_card_mode_sel)) else $error("mode select changed alone");
    c_overrun: cover property (i_rx_done && o_rx_full_request);
    c_dma_refill: cover property (i_dma_wr && o_tx_data_request);
    c_smart_card: cover property (o_smart_card_mode_sel);
endmodule // uart_status_flags_assertions

bind uart_status_flags uart_status_flags_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .i_tx_load(i_tx_load),
    .i_rx_done(i_rx_done), .i_rx_framing_err(i_rx_framing_err),
    .i_rx_parity_err(i_rx_parity_err), .i_dma_wr(i_dma_wr), .o_tx_enable(o_tx_enable),
    .o_smart_card_mode_sel(o_smart_card_mode_sel), .o_tx_data_request(o_tx_data_request),
    .o_rx_full_request(o_rx_full_request), .o_rx_error_request(o_rx_error_request));

// ===== tb/uart_far_end.sv
// Far side model: serial peer events and the DMA controller refilling tx data.
// Assumes it shares i_clk with the block; the bench calls its tasks.
`timescale 1ns/1ns
module uart_far_end (
    input wire logic i_clk,
    input wire logic i_tx_req,
    output logic o_tx_load = 1'b0,
    output logic o_tx_last_bit = 1'b0,
    output logic o_rx_done = 1'b0,
    output logic o_fe = 1'b0,
    output logic o_pe = 1'b0,
    output logic o_dma_wr = 1'b0,
    output logic [7:0] o_rx_data = 8'h00,
    output logic [7:0] o_dma_data = 8'h00
);
    // One frame end; stale data is inverted so nothing relies on held values
    task automatic frame(input logic [7:0] d, input logic fe, input logic pe);
        @(posedge i_clk);
        o_rx_done <= 1'b1;
        {o_rx_data, o_fe, o_pe} <= {d, fe, pe};
        @(posedge i_clk);
        o_rx_done <= 1'b0;
        {o_rx_data, o_fe, o_pe} <= ~{d, fe, pe};
    endtask
    // Shifter pulse: holding-to-shift transfer, or last bit sent
    task automatic tx_event(input logic last);
        @(posedge i_clk);
        {o_tx_last_bit, o_tx_load} <= {last, !last};
        @(posedge i_clk);
        {o_tx_last_bit, o_tx_load} <= 2'b00;
    endtask
    // DMA writes after seeing the request, or after 50 cycles without it, then promptly or after lag cycles
    task automatic dma_service(input int lag, input logic [7:0] d);
        int n;
        n = 0;
        while (i_tx_req !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        repeat (lag + 1) @(posedge i_clk);
        o_dma_wr <= 1'b1;
        o_dma_data <= d;
        @(posedge i_clk);
        o_dma_wr <= 1'b0;
        o_dma_data <= ~d;
    endtask
endmodule // uart_far_end

// ===== tb/tb_uart_status_flags.sv
// Self-checking bench for the serial status block with a far side model.
// Assumes the register header is on the include path; one 25 MHz clock.
`timescale 1ns/1ns
`include "uart_status_flags_consts.vh"
module tb_uart_status_flags;
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [25:0] adr = 26'h0;
    logic [31:0] wdat = 32'h0, rd;
    logic [7:0] st, d;
    wire [31:0] rdat;
    wire ack, ld, lb, rxd, fe, pe, dw, txen, rxen, scs, txq, rxq, erq, irq;
    wire [7:0] rxdat, dmad, txh;
    int n_errors = 0, comparisons = 0;
    initial forever #20 clk = ~clk;
    uart_status_flags i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_tx_load(ld), .i_tx_last_bit(lb), .i_rx_done(rxd),
        .i_rx_data(rxdat), .i_rx_framing_err(fe), .i_rx_parity_err(pe), .i_dma_wr(dw),
        .i_dma_data(dmad), .o_tx_holding(txh), .o_tx_enable(txen), .o_rx_enable(rxen),
        .o_smart_card_mode_sel(scs), .o_tx_data_request(txq), .o_rx_full_request(rxq),
        .o_rx_error_request(erq), .o_irq(irq));
    uart_far_end i_peer (.i_clk(clk), .i_tx_req(txq), .o_tx_load(ld), .o_tx_last_bit(lb),
        .o_rx_done(rxd), .o_fe(fe), .o_pe(pe), .o_dma_wr(dw), .o_rx_data(rxdat),
        .o_dma_data(dmad));
    // ********************
    // Bench tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [23:0] idx, input logic [7:0] v);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, 24'h0, v};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            n_errors++;
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rdchk(input logic [23:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    // Let the edge after a pulse or write land before looking at ports
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    // Zero write clears armed flags; transmit end follows the empty flag
    function automatic logic [7:0] cleared(input logic [7:0] s, input logic [7:0] w);
        logic [7:0] r;
        r = s & (w | ~`STATUS_W0C_MASK);
        if (!r[7])
            r[2] = 1'b0;
        return r;
    endfunction
    task automatic clr(input logic [7:0] w);
        bus(1'b0, `IDX_SERIAL_STATUS, 8'h00);
        bus(1'b1, `IDX_SERIAL_STATUS, w);
        st = cleared(st, w);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        test_done;
    end
    // ********************
    // Tests
    // ********************
    initial begin
        void'($urandom(14));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(`IDX_SERIAL_STATUS, 8'h84);
        rdchk(24'hFFFF87, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            d = $urandom;
            bus(1'b1, `IDX_SMART_CARD_MODE, {d[7:1], i[0]});
            settle;
            chk(scs, i[0]);
        end
        rdchk(`IDX_SMART_CARD_MODE, 8'h01);
        $display("test mode select done");
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hF0);
        bus(1'b1, `IDX_SERIAL_STATUS, 8'hFF);
        st = 8'h84;
        rdchk(`IDX_SERIAL_STATUS, st);
        clr(8'h00);
        rdchk(`IDX_SERIAL_STATUS, st);
        chk(txq, 1'b0);
        i_peer.tx_event(1'b0);
        rdchk(`IDX_SERIAL_STATUS, 8'h80);
        i_peer.tx_event(1'b1);
        rdchk(`IDX_SERIAL_STATUS, 8'h84);
        for (int lag = 0; lag < 4; lag += 3) begin
            d = $urandom;
            i_peer.dma_service(lag, d);
            rdchk(`IDX_SERIAL_STATUS, 8'h00);
            chk(txh, d);
            i_peer.tx_event(1'b0);
        end
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hD0);
        rdchk(`IDX_SERIAL_CONTROL, 8'hD0);
        chk(txen, 1'b0);
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hF0);
        st = 8'h84;
        rdchk(`IDX_SERIAL_STATUS, st);
        $display("test transmit flags done");
        d = $urandom;
        i_peer.frame(d, 1'b0, 1'b0);
        settle;
        chk(rxq, 1'b1);
        i_peer.frame(~d, 1'b0, 1'b0);
        rdchk(`IDX_RX_HOLDING, d);
        st = 8'hE4;
        rdchk(`IDX_SERIAL_STATUS, st);
        chk(erq, 1'b1);
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hE0);
        rdchk(`IDX_SERIAL_STATUS, st);
        chk({txen, rxen}, 2'b10);
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hF0);
        bus(1'b1, `IDX_SERIAL_STATUS, 8'hFF);
        bus(1'b1, `IDX_SERIAL_STATUS, 8'h00);
        rdchk(`IDX_SERIAL_STATUS, st);
        clr(8'hBF);
        rdchk(`IDX_SERIAL_STATUS, st);
        clr(8'h00);
        rdchk(`IDX_SERIAL_STATUS, st);
        $display("test receive flags done");
        for (int k = 1; k < 4; k++) begin
            i_peer.frame($urandom, k[0], k[1]);
            st = st | {3'b000, k[0], k[1], 3'b000};
            rdchk(`IDX_SERIAL_STATUS, st);
            chk({rxq, erq}, 2'b01);
        end
        clr(8'h00);
        rdchk(`IDX_SERIAL_STATUS, 8'h00);
        $display("test receive errors done");
        i_peer.tx_event(1'b0);
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        i_peer.frame($urandom, 1'b1, 1'b0);
        settle;
        chk(irq, 1'b0);
        bus(1'b1, `IDX_IRQ_MASK, 8'hFC);
        settle;
        chk(irq, 1'b1);
        rdchk(`IDX_IRQ_STATUS, 8'h10);
        settle;
        chk(irq, 1'b0);
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'h30);
        settle;
        chk({txq, rxq, erq}, 3'b000);
        bus(1'b1, `IDX_SERIAL_CONTROL, 8'hF0);
        settle;
        chk({txq, rxq, erq}, 3'b101);
        $display("test requests and interrupt done");
        test_done;
    end
endmodule // tb_uart_status_flags
